// [hw/mdio_port.sv]
// Behaviour
// - twenty digital lines, 20-bit setting
// - each write carries mask and value
// - value bit k drives line k
// - set bit drives high (off), clear low
// - read request returns current line setting
// - eight relay pairs, bit k is pair k+1
// - zero bit closes pair, one opens it
`timescale 1ns/1ps
`default_nettype none
module mdio_port #(
  parameter int LINES = mdio_pkg::LINE_COUNT,
  parameter int PAIRS = mdio_pkg::PAIR_COUNT
) (
  input  wire logic             ref_clk,   // 50 MHz system clock
  input  wire logic             rst,       // sync reset, active high
  input  wire logic             cmdValid,  // command strobe, one cycle
  input  wire logic [1:0]       cmdCode,   // command code
  input  wire logic [LINES-1:0] cmdMask,   // mask word
  input  wire logic [LINES-1:0] cmdValue,  // value word
  output logic      [LINES-1:0] lineOut,   // digital line levels
  output logic      [PAIRS-1:0] relayClose,// high closes relay pair
  output logic      [LINES-1:0] readData,  // line setting read back
  output logic                  readValid  // read answer pulse
);
  import mdio_pkg::*;

  // decode shared by the three command kinds
  function automatic logic cmd_hit
  (
    input logic       valid,
    input logic [1:0] code,
    input logic [1:0] want
  );
    cmd_hit = valid && (code == want);
  endfunction

  logic [LINES-1:0] lineState;
  logic [LINES-1:0] lineLevel;
  logic [LINES-1:0] lineMask;
  logic [LINES-1:0] lineValue;
  logic [PAIRS-1:0] pairState;
  logic [PAIRS-1:0] pairClose;
  logic [PAIRS-1:0] pairMask;
  logic [PAIRS-1:0] pairValue;
  logic             lineWrite;
  logic             relayWrite;
  logic             lineRead;
  logic [LINES-1:0] readData_r;
  logic [LINES-1:0] readData_nxt;
  logic             readValid_r;
  logic             readValid_nxt;

  // full mask means every bit is driven
  assign lineWrite  = cmd_hit(cmdValid, cmdCode, CMD_LINE_WRITE);
  assign relayWrite = cmd_hit(cmdValid, cmdCode, CMD_RELAY_WRITE);
  assign lineRead   = cmd_hit(cmdValid, cmdCode, CMD_LINE_READ);

  // relay words use the low byte of the command words
  assign lineMask  = cmdMask;
  assign lineValue = cmdValue;
  assign pairMask  = cmdMask[PAIRS-1:0];
  assign pairValue = cmdValue[PAIRS-1:0];

  mdio_masked_reg #(
    .WIDTH     (LINES),
    .RESET_VAL (LINE_RESET[LINES-1:0])
  ) u_lines (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wrEn    (lineWrite),
    .mask    (lineMask),
    .value   (lineValue),
    .state   (lineState)
  );

  mdio_masked_reg #(
    .WIDTH     (PAIRS),
    .RESET_VAL (PAIR_RESET[PAIRS-1:0])
  ) u_relays (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wrEn    (relayWrite),
    .mask    (pairMask),
    .value   (pairValue),
    .state   (pairState)
  );

  genvar gLine;
  genvar gPair;

  // bit k straight to line k; one level means high and off
  generate
    for (gLine = 0; gLine < LINES; gLine++)
    begin : g_line
      assign lineLevel[gLine] = lineState[gLine];
    end
  endgenerate

  // active-low convention: cleared bit closes the pair
  generate
    for (gPair = 0; gPair < PAIRS; gPair++)
    begin : g_pair
      assign pairClose[gPair] = ~pairState[gPair];
    end
  endgenerate

  assign lineOut    = lineLevel;
  assign relayClose = pairClose;

  // capture holds until the next read, so a slow host still sees it
  assign readData_nxt  = lineRead ? lineState : readData_r;
  assign readValid_nxt = lineRead;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      readData_r  <= '0;
      readValid_r <= 1'b0;
    end
    else
    begin
      readData_r  <= readData_nxt;
      readValid_r <= readValid_nxt;
    end
  end

  assign readData  = readData_r;
  assign readValid = readValid_r;
endmodule
`default_nettype wire

// [hw/mdio_pkg.sv]
`default_nettype none
package mdio_pkg;
  localparam int LINE_COUNT = 20;
  localparam int PAIR_COUNT = 8;
  localparam logic [19:0] LINE_RESET = 20'hfffff;
  localparam logic [7:0]  PAIR_RESET = 8'hff;
  localparam logic [1:0]  CMD_LINE_WRITE  = 2'h1;
  localparam logic [1:0]  CMD_LINE_READ   = 2'h2;
  localparam logic [1:0]  CMD_RELAY_WRITE = 2'h3;
endpackage
`default_nettype wire

// [hw/mdio_masked_reg.sv]
`timescale 1ns/1ps
`default_nettype none
module mdio_masked_reg #(
  parameter int             WIDTH     = 20,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input  wire logic             ref_clk, // system clock
  input  wire logic             rst,     // sync reset, active high
  input  wire logic             wrEn,    // apply masked write
  input  wire logic [WIDTH-1:0] mask,    // bits to change
  input  wire logic [WIDTH-1:0] value,   // new bit values
  output logic      [WIDTH-1:0] state    // held setting
);
  logic [WIDTH-1:0] state_r;
  logic [WIDTH-1:0] state_nxt;

  // unmasked bits keep their old value
  assign state_nxt = (state_r & ~mask) | (value & mask);
  assign state     = state_r;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_r <= RESET_VAL;
    else if (wrEn)
      state_r <= state_nxt;
  end
endmodule
`default_nettype wire

// [test/mdio_port_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module mdio_port_chk (
  input wire logic ref_clk, rst, cmdValid, readValid,
  input wire logic [1:0] cmdCode, input wire logic [19:0] cmdMask,
  input wire logic [19:0] cmdValue, lineOut, readData,
  input wire logic [7:0] relayClose);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic lw = cmdValid && cmdCode == 2'h1, rd = cmdValid && cmdCode == 2'h2;
  property p_lv; lw|=>!((lineOut^$past(cmdValue))&$past(cmdMask)); endproperty
  a_lv: assert property (p_lv) else $error("line value");
  property p_st; !lw|=>$stable(lineOut); endproperty
  a_st: assert property (p_st) else $error("line kept");
  property p_rd; rd|=>readValid&&readData==$past(lineOut); endproperty
  a_rd: assert property (p_rd) else $error("read");
  wire logic rw = cmdValid && cmdCode == 2'h3;
  property p_rl;
    rw |=> !((relayClose ^ ~$past(cmdValue[7:0])) & $past(cmdMask[7:0]));
  endproperty
  a_rl: assert property (p_rl) else $error("relay value");
  property p_rs; !rw |=> $stable(relayClose); endproperty
  a_rs: assert property (p_rs) else $error("relay kept");
  property p_rv; !rd |=> !readValid; endproperty
  a_rv: assert property (p_rv) else $error("read pulse");
  property p_rk; !rd |=> $stable(readData); endproperty
  a_rk: assert property (p_rk) else $error("read held");
endmodule
`default_nettype wire

// [test/mdio_load.sv]
`timescale 1ns/1ps
`default_nettype none
module mdio_load (input wire logic [19:0] level, output logic [19:0] lineOn);
  assign lineOn = ~level;
endmodule
`default_nettype wire

// [test/tb_mdio_port.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_mdio_port;
  logic ref_clk = 0, rst = 1, cmdValid = 0, readValid;
  logic [1:0] cmdCode = 0;
  logic [19:0] cmdMask = 0, cmdValue = 0, lineOut, readData, lineOn;
  logic [7:0] relayClose;
  int failures = 0, compares = 0;
  always #10 ref_clk = ~ref_clk;
  mdio_port mdio_port_i (.*);
  mdio_load mdio_load_i (.level(lineOut), .lineOn(lineOn));
  // strobe stays up between calls, so back-to-back commands never glitch
  task automatic send(logic [1:0] c, logic [19:0] m, v);
    {cmdValid, cmdCode, cmdMask, cmdValue} = {1'b1, c, m, v};
    @(posedge ref_clk) #1;
  endtask
  task automatic chk(logic [19:0] got, exp);
    compares++;
    failures += int'(got !== exp);
    if (got !== exp) $display("[FAIL] %0t got %h", $time, got);
  endtask
  task automatic t_port;
    for (int k = 0; k < 20; k++)
    begin
      send(2'h1, 20'hfffff, 20'h1 << k);
      chk(lineOn, ~(20'h1 << k));
      chk({19'h0, readValid}, 20'h0);
      send(2'h2, 20'h0, 20'h0);
      chk(readData, 20'h1 << k);
      chk({19'h0, readValid}, 20'h1);
    end
    send(2'h1, 20'hff, 20'hf0);
    chk(lineOut, 20'h800f0);
    send(2'h3, 20'hff, 20'h80);
    chk({12'h0, relayClose}, 20'h7f);
    send(2'h0, 20'hfffff, 20'h0);
    chk(lineOut, 20'h800f0);
    $display("port test done");
  endtask
  task automatic t_reset;
    rst = 1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(lineOut, 20'hfffff);
    chk({12'h0, relayClose}, 20'h0);
    chk(readData, 20'h0);
    chk({19'h0, readValid}, 20'h0);
    rst = 0;
    send(2'h1, 20'hfffff, 20'h0);
    chk(lineOut, 20'h0);
    $display("reset test done");
  endtask
  task automatic give_verdict(int extra);
    failures += extra;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    #1 rst = 0;
    t_port;
    t_reset;
    give_verdict(0);
  end
  initial #30000 give_verdict(1);
endmodule
bind mdio_port mdio_port_chk mdio_port_chk_i (.*);
`default_nettype wire
